// File: rtl/cbsc_regs.svh
// Offsets, reset values, write masks and bus constants of the clock buffer configuration bank
`ifndef CBSC_REGS_SVH
`define CBSC_REGS_SVH
`define CBSC_OFF_CTRL0 7'h00
`define CBSC_OFF_OE 7'h01
`define CBSC_OFF_STOPSEL 7'h02
`define CBSC_OFF_RSVD3 7'h03
`define CBSC_OFF_ID 7'h04
`define CBSC_OFF_RSVD5 7'h05
`define CBSC_RST_CTRL0 8'h07
`define CBSC_RST_OE 8'hff
`define CBSC_RST_STOPSEL 8'h00
`define CBSC_RST_RSVD 8'h00
`define CBSC_WMASK_CTRL0 8'hc7
`define CBSC_WMASK_OE 8'h66
`define CBSC_WMASK_STOPSEL 8'h66
`define CBSC_BIT_PD_MODE 7
`define CBSC_BIT_STOP_MODE 6
`define CBSC_BIT_BW 2
`define CBSC_BIT_PLL 1
`define CBSC_BIT_RATE 0
`define CBSC_SLAVE_ADDR 7'h6e
`define CBSC_BYTE_OP 3'b100
`define CBSC_BLOCK_COUNT 8'h06
`define CBSC_STRAP_WAIT 2'h3
`endif

// File: rtl/cbsc_pkg.sv
// Types shared by the clock buffer configuration bank
package cbsc_pkg;
    typedef enum logic [2:0] {CBSC_IDLE, CBSC_ADDR, CBSC_CMD, CBSC_WDATA, CBSC_ACK, CBSC_RDATA, CBSC_RACK} cbsc_state_t;
    typedef struct packed {
        logic pd_tristate;
        logic stop_tristate;
        logic bw_low;
        logic pll_mode;
        logic full_rate;
        logic [3:0] run;
        logic [3:0] stoppable;
        logic power_down;
        logic output_stop;
    } cbsc_cfg_t;
endpackage

// File: rtl/cbsc_config_regs.sv
// SMBus configuration register bank of a differential clock buffer
`timescale 1ns/1ps
`include "cbsc_regs.svh"

// Functional notes
// - Byte write acknowledged after address, command, data.
// - Byte read uses repeated start, host nacks.
// - Command 1xxxxxxx is byte op, offset bits 6:0.
// - Ctrl0 bit7 power-down tri-state mode, reset 0.
// - Ctrl0 bit6 stop tri-state mode, reset 0.
// - Ctrl0 bit2 low bandwidth select, reset 1.
// - Ctrl0 bit1 PLL mode select, reset 1.
// - Ctrl0 bit0 full rate select, reset 1.
// - Enable register bits 6,5,2,1 enable outputs.
// - Stop select bits mark outputs stoppable.
// - Reserved bits keep their reset values.
// - Identification byte: revision high, vendor low.
// - Polarity strap sampled on the first three clocks after each reset, then held.
// - Strap inverts power-down, stop, enable polarity.
// - Responds to address 6Eh, supports block transfers.
// - All registers load defaults at reset.
// - Outputs 1 and 6 run only if bit and pin enable; outputs 2 and 5 follow the bit alone.
module cbsc_config_regs
    import cbsc_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h2,  // Arbitrary value
    parameter logic [3:0] VENDOR = 4'h5     // Arbitrary value
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_polarity_strap,
    input wire logic i_power_down_input,
    input wire logic i_output_stop_input,
    input wire logic i_oe_pin_one,
    input wire logic i_oe_pin_six,
    output cbsc_cfg_t o_cfg
);
    // ==========================================================
    // Input synchronisers
    logic [6:0] sync1_q, sync2_q;
    logic scl_p_q, sda_p_q;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_q <= 7'h03;
            sync2_q <= 7'h03;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            sync1_q <= {i_oe_pin_six, i_oe_pin_one, i_output_stop_input, i_power_down_input,
                        i_polarity_strap, i_scl, i_sda};
            sync2_q <= sync1_q;
            scl_p_q <= sync2_q[1];
            sda_p_q <= sync2_q[0];
        end
    end
    logic sda_s, scl_s, rise, fall, start_ev, stop_ev;
    assign sda_s = sync2_q[0];
    assign scl_s = sync2_q[1];
    assign rise = scl_s & ~scl_p_q;
    assign fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ==========================================================
    // Register helpers
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction
    logic [7:0] ctrl0_q, oe_q, stopsel_q;
    function automatic logic [7:0] read_reg(input logic [6:0] off);
        case (off)
            `CBSC_OFF_CTRL0: read_reg = ctrl0_q;
            `CBSC_OFF_OE: read_reg = oe_q;
            `CBSC_OFF_STOPSEL: read_reg = stopsel_q;
            `CBSC_OFF_ID: read_reg = {REVISION, VENDOR};
            default: read_reg = `CBSC_RST_RSVD;
        endcase
    endfunction

    // ==========================================================
    // SMBus slave
    cbsc_state_t st_q, st_d, nxt_q, nxt_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ctrl0_d, oe_d, stopsel_d, byte_in, tx;
    logic [6:0] ptr_q, ptr_d;
    logic block_q, block_d, first_q, first_d, drv_q, drv_d;
    assign byte_in = {sh_q[6:0], sda_s};
    always_comb
    begin
        st_d = st_q;
        nxt_d = nxt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        block_d = block_q;
        first_d = first_q;
        drv_d = drv_q;
        ctrl0_d = ctrl0_q;
        oe_d = oe_q;
        stopsel_d = stopsel_q;
        tx = read_reg(ptr_q);
        if (start_ev)
        begin
            st_d = CBSC_ADDR;
            bit_d = 3'h0;
            drv_d = 1'b0;
        end
        else if (stop_ev)
        begin
            st_d = CBSC_IDLE;
            drv_d = 1'b0;
        end
        else
        begin
            case (st_q)
                CBSC_ADDR, CBSC_CMD, CBSC_WDATA:
                begin
                    if (rise)
                    begin
                        sh_d = byte_in;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            st_d = CBSC_ACK;
                            if (st_q == CBSC_ADDR)
                            begin
                                if (byte_in[7:1] != `CBSC_SLAVE_ADDR)
                                    st_d = CBSC_IDLE;
                                nxt_d = byte_in[0] ? CBSC_RDATA : CBSC_CMD;
                            end
                            else if (st_q == CBSC_CMD)
                            begin
                                nxt_d = CBSC_WDATA;
                                block_d = ~byte_in[7];
                                first_d = ~byte_in[7];
                                ptr_d = byte_in[7] ? byte_in[6:0] : 7'h00;
                            end
                            else
                            begin
                                nxt_d = CBSC_WDATA;
                                if (block_q && first_q)
                                    first_d = 1'b0;
                                else
                                begin
                                    ptr_d = ptr_q + 7'h01;
                                    // Masked merge leaves reserved bits at reset value
                                    if (ptr_q == `CBSC_OFF_CTRL0)
                                        ctrl0_d = merge(ctrl0_q, byte_in, `CBSC_WMASK_CTRL0);
                                    if (ptr_q == `CBSC_OFF_OE)
                                        oe_d = merge(oe_q, byte_in, `CBSC_WMASK_OE);
                                    if (ptr_q == `CBSC_OFF_STOPSEL)
                                        stopsel_d = merge(stopsel_q, byte_in, `CBSC_WMASK_STOPSEL);
                                end
                            end
                        end
                    end
                end
                CBSC_ACK:
                begin
                    if (fall)
                    begin
                        if (!drv_d)
                            drv_d = 1'b1;
                        else
                        begin
                            drv_d = 1'b0;
                            st_d = nxt_q;
                            bit_d = 3'h0;
                            if (nxt_q == CBSC_RDATA)
                            begin
                                if (block_q && first_q)
                                begin
                                    tx = `CBSC_BLOCK_COUNT;
                                    first_d = 1'b0;
                                end
                                else
                                    ptr_d = ptr_q + 7'h01;
                                sh_d = tx;
                                drv_d = ~tx[7];
                            end
                        end
                    end
                end
                CBSC_RDATA:
                begin
                    if (fall)
                    begin
                        if (bit_q == 3'h7)
                        begin
                            drv_d = 1'b0;
                            bit_d = 3'h0;
                            st_d = CBSC_RACK;
                        end
                        else
                        begin
                            bit_d = bit_q + 3'h1;
                            sh_d = {sh_q[6:0], 1'b0};
                            drv_d = ~sh_q[6];
                        end
                    end
                end
                CBSC_RACK:
                begin
                    if (rise)
                    begin
                        if (sda_s)
                            st_d = CBSC_IDLE;
                        else
                            bit_d = 3'h1;
                    end
                    else if (fall && bit_q == 3'h1)
                    begin
                        st_d = CBSC_RDATA;
                        bit_d = 3'h0;
                        ptr_d = ptr_q + 7'h01;
                        sh_d = tx;
                        drv_d = ~tx[7];
                    end
                end
                default: st_d = CBSC_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= CBSC_IDLE;
            nxt_q <= CBSC_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 7'h00;
            block_q <= 1'b0;
            first_q <= 1'b0;
            drv_q <= 1'b0;
            ctrl0_q <= `CBSC_RST_CTRL0;
            oe_q <= `CBSC_RST_OE;
            stopsel_q <= `CBSC_RST_STOPSEL;
        end
        else
        begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            block_q <= block_d;
            first_q <= first_d;
            drv_q <= drv_d;
            ctrl0_q <= ctrl0_d;
            oe_q <= oe_d;
            stopsel_q <= stopsel_d;
        end
    end
    assign o_sda_out = 1'b0;
    assign o_sda_oe = drv_q;

    // ==========================================================
    // Strap capture and pin polarity
    logic [1:0] wait_q, wait_d;
    logic strap_q, strap_d, pin_one_on, pin_six_on;
    cbsc_cfg_t cfg_d;
    always_comb
    begin
        wait_d = wait_q;
        strap_d = strap_q;
        if (wait_q != `CBSC_STRAP_WAIT)
        begin
            wait_d = wait_q + 2'h1;
            strap_d = sync2_q[2];
        end
        pin_one_on = sync2_q[5] ^ strap_q;
        pin_six_on = sync2_q[6] ^ strap_q;
        cfg_d.pd_tristate = ctrl0_q[`CBSC_BIT_PD_MODE];
        cfg_d.stop_tristate = ctrl0_q[`CBSC_BIT_STOP_MODE];
        cfg_d.bw_low = ctrl0_q[`CBSC_BIT_BW];
        cfg_d.pll_mode = ctrl0_q[`CBSC_BIT_PLL];
        cfg_d.full_rate = ctrl0_q[`CBSC_BIT_RATE];
        cfg_d.run = {oe_q[6] & pin_six_on, oe_q[5], oe_q[2], oe_q[1] & pin_one_on};
        cfg_d.stoppable = {stopsel_q[6], stopsel_q[5], stopsel_q[2], stopsel_q[1]};
        cfg_d.power_down = sync2_q[3] ~^ strap_q;
        cfg_d.output_stop = sync2_q[4] ~^ strap_q;
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wait_q <= 2'h0;
            strap_q <= 1'b0;
            o_cfg <= '0;
        end
        else
        begin
            wait_q <= wait_d;
            strap_q <= strap_d;
            o_cfg <= cfg_d;
        end
    end

    // ==========================================================
    // Checks
    start_addr_a: assert property (@(posedge i_clk) disable iff (i_rst) start_ev |=> st_q == CBSC_ADDR)
        else $error("start not seen");
    stop_release_a: assert property (@(posedge i_clk) disable iff (i_rst) stop_ev |=> !o_sda_oe)
        else $error("sda held after stop");
    byte_offset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == CBSC_CMD && rise && bit_q == 3'h7 && !start_ev && !stop_ev && byte_in[7])
        |=> ptr_q == $past(byte_in[6:0]))
        else $error("byte offset wrong");
    rsvd_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (oe_q | `CBSC_WMASK_OE) == 8'hff && (ctrl0_q & ~`CBSC_WMASK_CTRL0) == 8'h00
        && (stopsel_q & ~`CBSC_WMASK_STOPSEL) == 8'h00)
        else $error("reserved bit changed");
    strap_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) wait_q == `CBSC_STRAP_WAIT |=> $stable(strap_q))
        else $error("strap resampled");
    pd_polarity_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_cfg.power_down == ($past(sync2_q[3]) ~^ $past(strap_q)))
        else $error("power down polarity");
    run_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_cfg.run[0] == $past(oe_q[1] & pin_one_on))
        else $error("output runs while disabled");
    ctrl_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_cfg.pd_tristate == $past(ctrl0_q[7]) && o_cfg.full_rate == $past(ctrl0_q[0]))
        else $error("control bit mapping");
    addr_nack_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == CBSC_ADDR && rise && bit_q == 3'h7 && !start_ev && !stop_ev
        && byte_in[7:1] != `CBSC_SLAVE_ADDR) |=> st_q == CBSC_IDLE ##1 !o_sda_oe)
        else $error("foreign address acknowledged");
endmodule // cbsc_config_regs

// File: verif/cbsc_smbus_host.sv
// SMBus host model driving the configuration bank serial port
`timescale 1ns/1ps
module cbsc_smbus_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // ==========
    // Bus phases
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Each level is held 8 clocks, above the 4 the port needs
    task automatic step(input logic s, input logic d);
        o_scl <= s;
        o_sda <= d;
        repeat (8) @(posedge i_clk);
    endtask
    // Data falls while the clock is high
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // Data rises while the clock is high
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Eight bits MSB first, then the acknowledge slot; NACK ends a read
    task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            step(1'b0, d[i]);
            step(1'b1, d[i]);
            r[i] = i_sda;
        end
    endtask
endmodule // cbsc_smbus_host

// File: verif/tb_top.sv
// Self-checking bench for the clock buffer configuration bank
`timescale 1ns/1ps
module tb_top;
    import cbsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b0;
    logic pd_pin = 1'b1;
    logic stop_pin = 1'b1;
    logic oe1 = 1'b1;
    logic oe6 = 1'b1;
    logic pol = 1'b0;
    logic scl;
    logic host_sda;
    logic sda_out;
    logic sda_oe;
    wire logic sda_bus;
    cbsc_cfg_t cfg;
    logic [7:0] mdl [0:6];
    int miscompares = 0;
    int samples_checked = 0;
    // ==========
    // Harness
    always #25 clk = ~clk;
    // Open-drain data line with pull-up
    assign sda_bus = host_sda & (sda_oe ? sda_out : 1'b1);
    cbsc_smbus_host host (.i_clk(clk), .i_sda(sda_bus), .o_scl(scl), .o_sda(host_sda));
    // Identification values are arbitrary
    cbsc_config_regs #(.REVISION(4'h3), .VENDOR(4'ha)) dut (
        .i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_bus), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_polarity_strap(strap), .i_power_down_input(pd_pin), .i_output_stop_input(stop_pin),
        .i_oe_pin_one(oe1), .i_oe_pin_six(oe6), .o_cfg(cfg));
    // ==========
    // Helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [7:0] wmask(input logic [6:0] o);
        case (o)
            7'h00: return 8'hc7;
            7'h01, 7'h02: return 8'h66;
            default: return 8'h00;
        endcase
    endfunction
    task automatic send(input logic [7:0] d, output logic ack);
        logic [8:0] r;
        host.xbyte({d, 1'b1}, r);
        ack = ~r[0];
    endtask
    task automatic head(input logic [7:0] c);
        logic k;
        host.start();
        send(8'hdc, k);
        chk("address ack", {15'h0, k}, 16'h1);
        send(c, k);
        chk("command ack", {15'h0, k}, 16'h1);
    endtask
    task automatic wr(input logic [6:0] o, input logic [7:0] d);
        logic k;
        head({1'b1, o});
        send(d, k);
        chk("data ack", {15'h0, k}, 16'h1);
        host.stop();
        mdl[o] = (d & wmask(o)) | (mdl[o] & ~wmask(o));
    endtask
    task automatic rd(input logic [7:0] c, input logic last, output logic [7:0] d);
        logic [8:0] r;
        logic k;
        head(c);
        host.start();
        send(8'hdd, k);
        chk("read address ack", {15'h0, k}, 16'h1);
        host.xbyte({8'hff, last}, r);
        d = r[8:1];
        if (last)
            host.stop();
    endtask
    task automatic read_all();
        logic [7:0] d;
        for (int o = 0; o < 7; o++)
        begin
            rd({1'b1, 7'(o)}, 1'b1, d);
            chk("register", {8'h0, d}, {8'h0, mdl[o]});
        end
    endtask
    // Random pins, then the whole configuration word
    task automatic check_cfg();
        cbsc_cfg_t e;
        logic en1;
        logic en6;
        {pd_pin, stop_pin, oe1, oe6} <= 4'($urandom);
        repeat (6) @(posedge clk);
        en1 = oe1 ^ pol;
        en6 = oe6 ^ pol;
        e = '{mdl[0][7], mdl[0][6], mdl[0][2], mdl[0][1], mdl[0][0],
            {mdl[1][6] & en6, mdl[1][5], mdl[1][2], mdl[1][1] & en1},
            {mdl[2][6], mdl[2][5], mdl[2][2], mdl[2][1]}, pd_pin ~^ pol, stop_pin ~^ pol};
        chk("cfg", {1'b0, cfg}, {1'b0, e});
    endtask
    task automatic do_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        pol = s;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        mdl = '{8'h07, 8'hff, 8'h00, 8'h00, {4'h3, 4'ha}, 8'h00, 8'h00};
    endtask
    // ==========
    // Tests
    initial
    begin : main
        logic [7:0] d;
        logic [8:0] r;
        logic k;
        void'($urandom(32'hedfa5e42));
        do_reset(1'b0);
        read_all();
        check_cfg();
        $display("test defaults done");
        for (int n = 0; n < 3; n++)
        begin
            for (int o = 0; o < 7; o++)
            begin
                d = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : 8'($urandom);
                wr(7'(o), d);
                check_cfg();
            end
            read_all();
        end
        $display("test writes done");
        host.start();
        send(8'hde, k);
        chk("foreign ack", {15'h0, k}, 16'h0);
        host.stop();
        rd(8'h00, 1'b0, d);
        chk("block count", {8'h0, d}, 16'h0006);
        host.xbyte({8'hff, 1'b1}, r);
        chk("block byte", {8'h0, r[8:1]}, {8'h0, mdl[0]});
        host.stop();
        head(8'h00);
        send(8'h02, k);
        chk("count ack", {15'h0, k}, 16'h1);
        for (int o = 0; o < 2; o++)
        begin
            d = 8'($urandom);
            send(d, k);
            chk("block data ack", {15'h0, k}, 16'h1);
            mdl[o] = (d & wmask(7'(o))) | (mdl[o] & ~wmask(7'(o)));
        end
        host.stop();
        read_all();
        $display("test address and block done");
        do_reset(1'b1);
        read_all();
        repeat (3) check_cfg();
        strap <= 1'b0;
        repeat (3) check_cfg();
        $display("test polarity done");
        test_done();
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        test_done();
    end
endmodule // tb_top
